/* File: design/stc_pkg.sv */
package stc_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_COUNT_LOW = 12'h004;
	localparam logic [11:0] ADDR_COUNT_HIGH = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_SYSTEM = 12'h010;
	// ****************************************
	// Control field positions
	// ****************************************
	localparam int BIT_WIDE = 7;
	localparam int BIT_ASSIGN_HI = 6;
	localparam int BIT_PRESCALE_HI = 5;
	localparam int BIT_PRESCALE_LO = 4;
	localparam int BIT_ASSIGN_LO = 3;
	localparam int BIT_SYNC_DISABLE = 2;
	localparam int BIT_CLOCK_SOURCE = 1;
	localparam int BIT_ON = 0;
	// System register fields
	localparam int BIT_IRQ_ENABLE = 0;
	localparam int BIT_OSC_ENABLE = 1;
	localparam int BIT_ADC_ENABLE = 2;
	// Status register fields
	localparam int BIT_OVERFLOW = 0;
	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;
	localparam int SYNC_STAGES = 3;
	// Edge qualifier states
	typedef enum logic [2:0] {
		EDGE_WAIT_FALL = 3'b001,
		EDGE_ARMED = 3'b010,
		EDGE_IDLE = 3'b100
	} stc_edge_t;
endpackage : stc_pkg

/* File: design/stc_tick_if.sv */
interface stc_tick_if;
	logic tick;
	logic armed;
	modport source (output tick, output armed);
	modport sink (input tick, input armed);
endinterface : stc_tick_if

/* File: design/stc_edge_detect.sv */
module stc_edge_detect (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Raw input and gate
	input wire logic rawClock,
	input wire logic active,
	// Tick out
	stc_tick_if.source tickOut
);
	logic [stc_pkg::SYNC_STAGES-1:0] syncChain;
	stc_pkg::stc_edge_t state;
	stc_pkg::stc_edge_t next_state;
	logic rise;
	logic fall;

	// Three-stage synchroniser on the pin
	always_ff @(posedge clock) begin
		if (rst) begin
			syncChain <= '0;
		end else begin
			syncChain <= {syncChain[stc_pkg::SYNC_STAGES-2:0], rawClock};
		end
	end

	// Rise counts while stage two is high and three low; a fall only arms
	assign rise = syncChain[1] & ~syncChain[2];
	assign fall = ~syncChain[1] & syncChain[2];

	// Arm only after the first falling edge is seen
	always_comb begin
		next_state = state;
		unique case (state)
			stc_pkg::EDGE_IDLE: begin
				if (active) begin
					next_state = stc_pkg::EDGE_WAIT_FALL;
				end
			end
			stc_pkg::EDGE_WAIT_FALL: begin
				if (!active) begin
					next_state = stc_pkg::EDGE_IDLE;
				end else if (fall) begin
					next_state = stc_pkg::EDGE_ARMED;
				end
			end
			stc_pkg::EDGE_ARMED: begin
				if (!active) begin
					next_state = stc_pkg::EDGE_IDLE;
				end
			end
			default: begin
				next_state = stc_pkg::EDGE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= stc_pkg::EDGE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// One-cycle tick per qualified rising edge
	assign tickOut.tick = rise && state == stc_pkg::EDGE_ARMED;
	assign tickOut.armed = state == stc_pkg::EDGE_ARMED;
endmodule : stc_edge_detect

/* File: design/stc_timer.sv */
// The APB slave port and the placing of the registers were decided locally.
module stc_timer (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and oscillator
	input wire logic externalClockPin,
	input wire logic lowFreqOsc,
	output logic oscPinInLow,
	output logic oscPinInHigh,
	// Compare units
	input wire logic [3:0] compareUnitOneMode,
	input wire logic [3:0] compareUnitTwoMode,
	input wire logic compareOneMatch,
	input wire logic compareTwoMatch,
	output logic unitOneUsesThis,
	output logic unitTwoUsesThis,
	// Events out
	output logic overflowIrq,
	output logic adcStart
);
	logic [7:0] control;
	logic [15:0] count;
	logic [7:0] highBuffer;
	logic overflowFlag;
	logic irqEnable;
	logic oscEnable;
	logic adcEnable;
	logic [2:0] prescaler;
	logic [2:0] pinSync;
	logic [2:0] oscSync;
	logic wrEn;
	logic rdEn;
	logic wide;
	logic writeLow;
	logic writeHigh;
	logic readLow;
	logic extSource;
	logic rawExt;
	logic rawTickAsync;
	logic asyncPrev;
	logic inputTick;
	logic prescaleDone;
	logic countEnable;
	logic trigOne;
	logic trigTwo;
	logic trigger;
	logic [7:0] wByte;
	stc_tick_if syncTick ();

	// ****************************************
	// APB decode
	// ****************************************
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wByte = pwdata[7:0];
	assign wide = control[stc_pkg::BIT_WIDE];
	assign writeLow = wrEn && paddr == stc_pkg::ADDR_COUNT_LOW;
	assign writeHigh = wrEn && paddr == stc_pkg::ADDR_COUNT_HIGH;
	assign readLow = rdEn && paddr == stc_pkg::ADDR_COUNT_LOW;

	// Control register
	always_ff @(posedge clock) begin
		if (rst) begin
			control <= stc_pkg::CONTROL_RESET;
		end else if (wrEn && paddr == stc_pkg::ADDR_CONTROL) begin
			control <= wByte;
		end
	end

	// System register: enables for interrupt, oscillator and converter
	always_ff @(posedge clock) begin
		if (rst) begin
			irqEnable <= 1'b0;
			oscEnable <= 1'b0;
			adcEnable <= 1'b0;
		end else if (wrEn && paddr == stc_pkg::ADDR_SYSTEM) begin
			irqEnable <= wByte[stc_pkg::BIT_IRQ_ENABLE];
			oscEnable <= wByte[stc_pkg::BIT_OSC_ENABLE];
			adcEnable <= wByte[stc_pkg::BIT_ADC_ENABLE];
		end
	end

	// Read data from a register; unmapped reads give zero
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				stc_pkg::ADDR_CONTROL: prdata <= {24'h000000, control};
				stc_pkg::ADDR_COUNT_LOW: prdata <= {24'h000000, count[7:0]};
				stc_pkg::ADDR_COUNT_HIGH: prdata <= {24'h000000, wide ? highBuffer : count[15:8]};
				stc_pkg::ADDR_STATUS: prdata <= {31'h00000000, overflowFlag};
				stc_pkg::ADDR_SYSTEM: prdata <= {29'h00000000, adcEnable, oscEnable, irqEnable};
				default: prdata <= '0;
			endcase
		end
	end

	// High-byte buffer: loaded on low read or high write in wide mode
	always_ff @(posedge clock) begin
		if (rst) begin
			highBuffer <= 8'h00;
		end else if (wide && writeHigh) begin
			highBuffer <= wByte;
		end else if (wide && readLow) begin
			highBuffer <= count[15:8];
		end
	end

	// ****************************************
	// Clock source selection
	// ****************************************
	assign extSource = control[stc_pkg::BIT_CLOCK_SOURCE];

	// Pins read zero while the oscillator owns them
	assign oscPinInLow = oscEnable ? 1'b0 : externalClockPin;
	assign oscPinInHigh = 1'b0;
	assign rawExt = oscEnable ? lowFreqOsc : externalClockPin;

	stc_edge_detect edgeUnit (
		.clock(clock),
		.rst(rst),
		.rawClock(rawExt),
		.active(extSource && control[stc_pkg::BIT_ON]),
		.tickOut(syncTick.source)
	);

	// Short unsynchronised path: one stage only, edge after arming
	always_ff @(posedge clock) begin
		if (rst) begin
			asyncPrev <= 1'b0;
		end else begin
			asyncPrev <= rawExt;
		end
	end
	assign rawTickAsync = rawExt && !asyncPrev && syncTick.armed;

	// Edge to count: internal every cycle, else synced or raw edge
	always_comb begin
		if (!extSource) begin
			inputTick = 1'b1;
		end else if (control[stc_pkg::BIT_SYNC_DISABLE]) begin
			inputTick = rawTickAsync;
		end else begin
			inputTick = syncTick.tick;
		end
	end

	// ****************************************
	// Prescaler and count enable
	// ****************************************
	always_comb begin
		unique case (control[stc_pkg::BIT_PRESCALE_HI:stc_pkg::BIT_PRESCALE_LO])
			2'b00: prescaleDone = 1'b1;
			2'b01: prescaleDone = prescaler[0];
			2'b10: prescaleDone = &prescaler[1:0];
			2'b11: prescaleDone = &prescaler;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prescaler <= stc_pkg::PRESCALE_RESET;
		end else if (writeLow) begin
			prescaler <= stc_pkg::PRESCALE_RESET;
		end else if (control[stc_pkg::BIT_ON] && inputTick) begin
			prescaler <= prescaler + 3'h1;
		end
	end

	assign countEnable = control[stc_pkg::BIT_ON] && inputTick && prescaleDone;

	// ****************************************
	// Compare unit assignment and trigger
	// ****************************************
	assign unitOneUsesThis = control[stc_pkg::BIT_ASSIGN_HI];
	assign unitTwoUsesThis = control[stc_pkg::BIT_ASSIGN_HI] | control[stc_pkg::BIT_ASSIGN_LO];
	assign trigOne = unitOneUsesThis && compareOneMatch && compareUnitOneMode == stc_pkg::MODE_SPECIAL_EVENT;
	assign trigTwo = unitTwoUsesThis && compareTwoMatch && compareUnitTwoMode == stc_pkg::MODE_SPECIAL_EVENT;
	assign trigger = trigOne || trigTwo;

	// Conversion start pulse, registered
	always_ff @(posedge clock) begin
		if (rst) begin
			adcStart <= 1'b0;
		end else begin
			adcStart <= trigger && adcEnable;
		end
	end

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			count <= stc_pkg::COUNT_RESET;
		end else if (writeLow) begin
			count[7:0] <= wByte;
			if (wide) begin
				count[15:8] <= highBuffer;
			end
		end else if (writeHigh && !wide) begin
			count[15:8] <= wByte;
		end else if (trigger) begin
			count <= stc_pkg::COUNT_RESET;
		end else if (countEnable) begin
			count <= count + 16'h0001;
		end
	end

	// Overflow flag: set wins over software clear (write one to clear)
	always_ff @(posedge clock) begin
		if (rst) begin
			overflowFlag <= 1'b0;
		end else if (countEnable && !trigger && !writeLow && !(writeHigh && !wide) && count == stc_pkg::COUNT_MAX) begin
			overflowFlag <= 1'b1;
		end else if (wrEn && paddr == stc_pkg::ADDR_STATUS && wByte[stc_pkg::BIT_OVERFLOW]) begin
			overflowFlag <= 1'b0;
		end
	end

	assign overflowIrq = overflowFlag && irqEnable;
endmodule : stc_timer

/* File: bench/stc_timer_monitor.sv */
module stc_timer_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins, compare unit and events
	input wire logic oscPinInLow,
	input wire logic oscPinInHigh,
	input wire logic [3:0] compareUnitTwoMode,
	input wire logic compareTwoMatch,
	input wire logic unitOneUsesThis,
	input wire logic unitTwoUsesThis,
	input wire logic overflowIrq,
	input wire logic adcStart
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	logic [2:0] sys;
	logic wrAcc;
	assign wrAcc = psel && penable && pwrite;
	// Shadow of control and system bits
	always_ff @(posedge clock) begin
		if (rst) begin
			ctl <= 8'h00;
			sys <= 3'h0;
		end else if (wrAcc && paddr == stc_pkg::ADDR_CONTROL) begin
			ctl <= pwdata[7:0];
		end else if (wrAcc && paddr == stc_pkg::ADDR_SYSTEM) begin
			sys <= pwdata[2:0];
		end
	end
	default clocking mcb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Trigger from unit two, then a one-cycle start
	sequence trigTwo;
		compareTwoMatch && unitTwoUsesThis && compareUnitTwoMode == stc_pkg::MODE_SPECIAL_EVENT;
	endsequence
	sequence onePulse;
		adcStart ##1 !adcStart;
	endsequence
	unit_one_map_a: assert property (unitOneUsesThis == ctl[6]) else $error("unit one base wrong");
	unit_two_map_a: assert property (unitTwoUsesThis == (ctl[6] | ctl[3])) else $error("unit two base wrong");
	osc_pin_zero_a: assert property (sys[1] |-> !oscPinInLow && !oscPinInHigh) else $error("pin not zero");
	irq_gate_a: assert property (overflowIrq |-> sys[0]) else $error("irq not gated");
	adc_start_a: assert property (trigTwo ##0 sys[2] |=> onePulse) else $error("no start pulse");
	adc_cause_a: assert property (adcStart |-> $past(sys[2])) else $error("start while disabled");
	ready_a: assert property (psel && penable |-> pready) else $error("pready low");
	no_error_a: assert property (psel && penable |-> !pslverr) else $error("pslverr raised");
	ctl_read_a: assert property (psel && penable && !pwrite && paddr == stc_pkg::ADDR_CONTROL |-> prdata[7:0] == ctl)
		else $error("control readback wrong");
endmodule : stc_timer_monitor

bind stc_timer stc_timer_monitor u_mon (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr,
	.oscPinInLow, .oscPinInHigh, .compareUnitTwoMode, .compareTwoMatch, .unitOneUsesThis, .unitTwoUsesThis,
	.overflowIrq, .adcStart);

/* File: bench/stc_clock_source_model.sv */
module stc_clock_source_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Bench control
	input wire logic run,
	input wire logic useOsc,
	// Clock lines, idle high
	output logic pinLevel,
	output logic oscLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase;
	// Toggle the chosen line every four cycles; first move is a fall
	always_ff @(posedge clock) begin
		phase <= (rst || !run) ? 2'h0 : phase + 2'h1;
		if (rst) begin
			pinLevel <= 1'b1;
			oscLevel <= 1'b1;
		end else if (run && phase == 2'h3 && useOsc) begin
			oscLevel <= !oscLevel;
		end else if (run && phase == 2'h3) begin
			pinLevel <= !pinLevel;
		end
	end
endmodule : stc_clock_source_model

/* File: bench/stc_timer_tb_top.sv */
module stc_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] diff;
		logic [1:0] uses;
	} stc_row_t;
	logic clock, rst, psel, penable, pwrite, run, useOsc, pin, osc, match1, match2;
	logic pready, u1, u2, irq, pinLo, pinHi;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [7:0] first;
	int errTotal, checksDone, cycles;
	// Control value, count gain over 24 cycles, unit use
	stc_row_t rows [6] = '{'{8'h01, 8'h18, 2'h0}, '{8'h19, 8'h0C, 2'h1}, '{8'h61, 8'h06, 2'h3},
		'{8'h79, 8'h03, 2'h3}, '{8'h05, 8'h18, 2'h0}, '{8'h00, 8'h00, 2'h0}};
	stc_timer DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
		.externalClockPin(pin), .lowFreqOsc(osc), .oscPinInLow(pinLo), .oscPinInHigh(pinHi),
		.compareUnitOneMode(4'hB), .compareUnitTwoMode(4'hB), .compareOneMatch(match1), .compareTwoMatch(match2),
		.unitOneUsesThis(u1), .unitTwoUsesThis(u2), .overflowIrq(irq), .adcStart());
	stc_clock_source_model srcModel (.clock, .rst, .run, .useOsc, .pinLevel(pin), .oscLevel(osc));
	// ********
	// Tasks
	// ********
	task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdq = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic testDone();
		if (errTotal == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : testDone
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errTotal++;
			testDone();
		end
	end
	// ********
	// Main sequence
	// ********
	initial begin
		{rst, psel, penable, pwrite, run, useOsc, match1, match2, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		xfer(stc_pkg::ADDR_CONTROL, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h00);
		foreach (rows[i]) begin
			xfer(stc_pkg::ADDR_CONTROL, 1'b1, rows[i].ctl);
			xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'h00);
			xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
			first = rdq[7:0];
			repeat (21) @(posedge clock);
			xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
			chk(8'(rdq[7:0] - first), rows[i].diff);
			chk({6'h00, u1, u2}, {6'h00, rows[i].uses});
		end
		// Buffered and plain byte access
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'h80);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b1, 8'hAB);
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'hCD);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b1, 8'h11);
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
		chk(rdq[7:0], 8'hCD);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b0, 8'h00);
		chk(rdq[7:0], 8'hAB);
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'h00);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b1, 8'h22);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h22);
		// Overflow flag and its enable
		xfer(stc_pkg::ADDR_SYSTEM, 1'b1, 8'h04);
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'h81);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b1, 8'hFF);
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'hFA);
		repeat (12) @(posedge clock);
		xfer(stc_pkg::ADDR_STATUS, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h01);
		chk({7'h00, irq}, 8'h00);
		xfer(stc_pkg::ADDR_SYSTEM, 1'b1, 8'h05);
		#1 chk({7'h00, irq}, 8'h01);
		xfer(stc_pkg::ADDR_STATUS, 1'b1, 8'h01);
		#1 chk({7'h00, irq}, 8'h00);
		// Trigger reset near the top, then a write in the trigger cycle
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'hB9);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b1, 8'hFF);
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'hF0);
		@(posedge clock);
		match2 <= 1'b1;
		@(posedge clock);
		match2 <= 1'b0;
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
		chk({3'h0, rdq[7:3]}, 8'h00);
		xfer(stc_pkg::ADDR_COUNT_HIGH, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h00);
		xfer(stc_pkg::ADDR_STATUS, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h00);
		fork
			xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'h40);
			begin
				repeat (2) @(posedge clock);
				match2 <= 1'b1;
				@(posedge clock);
				match2 <= 1'b0;
			end
		join
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
		chk(rdq[7:0], 8'h40);
		// Unit one trigger resets the count only once assigned
		@(posedge clock);
		match1 <= 1'b1;
		@(posedge clock);
		match1 <= 1'b0;
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
		chk({6'h00, rdq[7:6]}, 8'h01);
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'hF9);
		@(posedge clock);
		match1 <= 1'b1;
		@(posedge clock);
		match1 <= 1'b0;
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
		chk({3'h0, rdq[7:3]}, 8'h00);
		// External pin synced, unsynced, then the oscillator
		xfer(stc_pkg::ADDR_SYSTEM, 1'b1, 8'h00);
		xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'h03);
		xfer(stc_pkg::ADDR_COUNT_LOW, 1'b1, 8'h00);
		for (int k = 0; k < 3; k++) begin
			if (k == 1) xfer(stc_pkg::ADDR_CONTROL, 1'b1, 8'h07);
			if (k == 2) xfer(stc_pkg::ADDR_SYSTEM, 1'b1, 8'h02);
			useOsc <= (k == 2);
			run <= 1'b1;
			repeat (40) @(posedge clock);
			run <= 1'b0;
			repeat (10) @(posedge clock);
			xfer(stc_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
			chk(rdq[7:0], 8'(5 * (k + 1)));
		end
		chk({6'h00, pinHi, pinLo}, 8'h00);
		testDone();
	end
endmodule : stc_timer_tb_top
